// ### logic/ttisgt_top.sv
// Notes on behaviour
// - Select bit picks external or internal tick
// - Read-only revision word at 20 hex
// - Decode frame into BCD, control, binary words
// - Done bit set by capture, cleared by software
// - Capture bit stores last frame, self clears
// - With tag reset, capture at reference edge
// - Tag reset at next reference edge, self clears
// - Binary seconds split across 16 and 14
// - Days high, hours low at 18 hex
// - Minutes high, seconds low at 1A hex
// - Twenty-seven control bits shown raw
// - Prescale 0 or 1 means 1 us
// - Preload is countdown start, changed when stopped
// - Zero preload never starts the timer
// - Control bits 1-3 act at zero
// - Bit 3 resets all modules at completion
// - Bit 2 raises timer interrupt at completion
// - Bit 0 runs timer, bit 1 reload
// - Reload mode reloads preload and continues
// - One-shot stops at zero, clears start
// - Stop holds count, start resumes it unless preload was rewritten
// - Timer interrupt shows as status bit 4
// - Write one to reset register clears
// - Internal 1 MHz tick source
module ttisgt_top (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_ext_tick,
    input wire logic i_irig_level,
    input wire logic [7:0] i_module_irq,
    output logic [7:0] o_module_irq_clr,
    output logic o_time_tag_tick,
    output logic o_time_tag_reset,
    output logic o_module_reset_all,
    output logic o_timer_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // Write strobes per register
    wire wr_irq_rst = i_wr_en && (i_addr == ttisgt_pkg::OFS_IRQ_RESET);
    wire wr_tick_sel = i_wr_en && (i_addr == ttisgt_pkg::OFS_TICK_SELECT);
    wire wr_sync = i_wr_en && (i_addr == ttisgt_pkg::OFS_SYNC_CTRL);
    wire wr_presc = i_wr_en && (i_addr == ttisgt_pkg::OFS_PRESCALE);
    wire wr_preload = i_wr_en && (i_addr == ttisgt_pkg::OFS_PRELOAD);
    wire wr_tctl = i_wr_en && (i_addr == ttisgt_pkg::OFS_TIMER_CTRL);

    // Tick generation
    logic [7:0] div_cnt; // Divider of the 200 MHz clock
    logic ext_q; // Last sample of the external tick
    logic tick_sel; // 1 = external source
    wire int_tick = (div_cnt == ttisgt_pkg::TICK_LAST); // Internal 1 us pulse
    wire ext_tick = i_ext_tick && !ext_q; // External rising edge
    // Free-running 1 MHz divider
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_cnt <= 8'h00;
        end else if (int_tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    // Source select and tick output
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            tick_sel <= 1'b0;
            ext_q <= 1'b0;
            o_time_tag_tick <= 1'b0;
        end else begin
            ext_q <= i_ext_tick;
            if (wr_tick_sel) begin
                tick_sel <= i_wdata[ttisgt_pkg::BIT_TICK_EXT];
            end
            // Registered so the timer and modules see one edge
            o_time_tag_tick <= tick_sel ? ext_tick : int_tick;
        end
    end

    // Time code receiver
    logic irig_q; // Last sample of the code input
    logic [13:0] width; // High time in us, saturating
    logic prev_mark; // Previous pulse was a marker
    logic locked; // Frame alignment found
    logic [6:0] pos; // Position of the pulse in flight
    logic [99:0] frame; // Bits of the frame in flight
    logic have_valid; // A whole frame has been decoded
    wire irig_rise = i_irig_level && !irig_q;
    wire irig_fall = !i_irig_level && irig_q;
    wire sym_mark = (width >= ttisgt_pkg::ONE_MAX_TICKS); // Pulse classified as marker
    wire sym_one = !sym_mark && (width >= ttisgt_pkg::ZERO_MAX_TICKS); // Pulse classified as one
    wire mark_pos = (pos == 7'd0) || ((pos % 7'd10) == 7'd9); // Position expects a marker
    wire ref_edge = irig_rise && locked && (pos == 7'd0); // On-time reference edge

    // Decoded words of the last valid frame
    logic [6:0] val_sec;
    logic [6:0] val_min;
    logic [5:0] val_hour;
    logic [9:0] val_day;
    logic [26:0] val_cf;
    logic [16:0] val_sbs;

    // Pulse width measurement on the internal tick
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irig_q <= 1'b0;
            width <= 14'h0000;
        end else begin
            irig_q <= i_irig_level;
            if (irig_rise) begin
                width <= 14'h0000;
            end else if (irig_q && int_tick && (width != 14'h3FFF)) begin
                width <= width + 14'h0001;
            end
        end
    end

    // Frame alignment and bit collection
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            prev_mark <= 1'b0;
            locked <= 1'b0;
            pos <= 7'd0;
            frame <= '0;
            have_valid <= 1'b0;
        end else if (irig_fall) begin
            prev_mark <= sym_mark;
            if (locked) begin
                // A misplaced marker drops lock until realigned
                if (sym_mark != mark_pos) begin
                    locked <= 1'b0;
                end else begin
                    frame[pos] <= sym_one;
                    if (pos == ttisgt_pkg::POS_LAST) begin
                        have_valid <= 1'b1;
                        pos <= 7'd0;
                    end else begin
                        pos <= pos + 7'd1;
                    end
                end
            end else if (sym_mark && prev_mark) begin
                // Two markers in a row: the second was the reference
                locked <= 1'b1;
                pos <= 7'd1;
            end
        end
    end

    // Latch the frame words when the last marker ends
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            val_sec <= '0;
            val_min <= '0;
            val_hour <= '0;
            val_day <= '0;
            val_cf <= '0;
            val_sbs <= '0;
        end else if (irig_fall && locked && sym_mark && pos == ttisgt_pkg::POS_LAST) begin
            // Fields are sent LSB first, tens after a gap bit
            val_sec <= {frame[ttisgt_pkg::POS_SEC+7 -: 3],
                        frame[ttisgt_pkg::POS_SEC+3 -: 4]};
            val_min <= {frame[ttisgt_pkg::POS_MIN+7 -: 3],
                        frame[ttisgt_pkg::POS_MIN+3 -: 4]};
            val_hour <= {frame[ttisgt_pkg::POS_HOUR+6 -: 2],
                         frame[ttisgt_pkg::POS_HOUR+3 -: 4]};
            val_day <= {frame[ttisgt_pkg::POS_DAY+11 -: 2],
                        frame[ttisgt_pkg::POS_DAY+8 -: 4],
                        frame[ttisgt_pkg::POS_DAY+3 -: 4]};
            val_cf <= {frame[ttisgt_pkg::POS_CF+28 -: 9],
                       frame[ttisgt_pkg::POS_CF+18 -: 9],
                       frame[ttisgt_pkg::POS_CF+8 -: 9]};
            val_sbs <= {frame[ttisgt_pkg::POS_SBS+17 -: 8],
                        frame[ttisgt_pkg::POS_SBS+8 -: 9]};
        end
    end
    // Synchronisation control
    logic tag_rst_req; // Waiting for the reference edge
    logic cap_req; // Capture pending
    logic sync_done; // Capture happened
    wire ref_hit = tag_rst_req && ref_edge; // Reference edge taken for a tag reset
    // A tag reset holds the capture until the edge itself
    wire cap_now = cap_req && have_valid && (!tag_rst_req || ref_hit);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            tag_rst_req <= 1'b0;
            cap_req <= 1'b0;
            sync_done <= 1'b0;
            o_time_tag_reset <= 1'b0;
        end else begin
            o_time_tag_reset <= ref_hit;
            if (wr_sync) begin
                tag_rst_req <= i_wdata[ttisgt_pkg::BIT_SYNC_TAG_RST];
                // A tag reset request also asks for a capture
                cap_req <= i_wdata[ttisgt_pkg::BIT_SYNC_CAPTURE] ||
                           i_wdata[ttisgt_pkg::BIT_SYNC_TAG_RST];
                sync_done <= i_wdata[ttisgt_pkg::BIT_SYNC_DONE];
            end
            if (ref_hit) begin
                tag_rst_req <= 1'b0;
            end
            // Hardware set wins over a software clear
            if (cap_now) begin
                cap_req <= 1'b0;
                sync_done <= 1'b1;
            end
        end
    end
    // Capture registers
    logic [16:0] cap_sbs;
    logic [9:0] cap_day;
    logic [5:0] cap_hour;
    logic [6:0] cap_min;
    logic [6:0] cap_sec;
    logic [26:0] cap_cf;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cap_sbs <= '0;
            cap_day <= '0;
            cap_hour <= '0;
            cap_min <= '0;
            cap_sec <= '0;
            cap_cf <= '0;
        end else if (cap_now) begin
            cap_sbs <= val_sbs;
            cap_day <= val_day;
            cap_hour <= val_hour;
            cap_min <= val_min;
            cap_sec <= val_sec;
            cap_cf <= val_cf;
        end
    end

    // General purpose timer
    logic run; // Start/stop bit
    logic reload_mode;
    logic irq_en;
    logic grst_en;
    logic [15:0] presc;
    logic [15:0] preload;
    logic [15:0] count;
    logic [15:0] presc_cnt; // Ticks within one period
    logic reload_pend; // Preload rewritten since last load
    // Values 0 and 1 both give a one-tick period
    wire [15:0] presc_last = (presc <= 16'h0001) ? 16'h0000 : presc - 16'h0001;
    wire period_end = run && o_time_tag_tick && (presc_cnt == presc_last); // Last tick of a period
    wire completion = period_end && (count == 16'h0001);
    wire start_fresh = (count == 16'h0000) || reload_pend; // Start must load the preload value

    // Settings are ignored while running, so they take hold only while the timer is stopped
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            presc <= ttisgt_pkg::RST_PRESCALE;
            preload <= ttisgt_pkg::RST_PRELOAD;
            {grst_en, irq_en, reload_mode} <= ttisgt_pkg::RST_TIMER_CTRL[3:1];
        end else if (!run) begin
            if (wr_presc) begin
                presc <= i_wdata;
            end
            if (wr_preload) begin
                preload <= i_wdata;
            end
            if (wr_tctl) begin
                reload_mode <= i_wdata[ttisgt_pkg::BIT_TC_RELOAD];
                irq_en <= i_wdata[ttisgt_pkg::BIT_TC_IRQ];
                grst_en <= i_wdata[ttisgt_pkg::BIT_TC_GRST];
            end
        end
    end

    // Count, run bit and prescaler
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            run <= ttisgt_pkg::RST_TIMER_CTRL[0];
            count <= 16'h0000;
            presc_cnt <= 16'h0000;
            reload_pend <= 1'b0;
        end else begin
            if (wr_preload && !run) begin
                reload_pend <= 1'b1;
            end
            if (wr_presc && !run) begin
                presc_cnt <= 16'h0000; // A stale count would miss the new period end
            end
            if (wr_tctl && !i_wdata[ttisgt_pkg::BIT_TC_RUN]) begin
                run <= 1'b0;
            end else if (wr_tctl && !run) begin
                if (!start_fresh) begin
                    run <= 1'b1;
                end else if (preload != 16'h0000) begin
                    run <= 1'b1;
                    count <= preload;
                    reload_pend <= 1'b0;
                    presc_cnt <= 16'h0000;
                end
                // Zero preload leaves the timer stopped
            end else if (run && o_time_tag_tick) begin
                presc_cnt <= period_end ? 16'h0000 : presc_cnt + 16'h0001;
                if (completion && reload_mode && preload != 16'h0000) begin
                    count <= preload;
                    reload_pend <= 1'b0;
                end else if (completion) begin
                    count <= 16'h0000;
                    run <= 1'b0;
                end else if (period_end) begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

    // Timer interrupt flag and module reset pulses
    logic irq_flag;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irq_flag <= 1'b0;
            o_module_reset_all <= 1'b0;
            o_module_irq_clr <= 8'h00;
        end else begin
            o_module_reset_all <= completion && grst_en;
            o_module_irq_clr <= wr_irq_rst ? {i_wdata[8:5], i_wdata[3:0]} : 8'h00;
            if (completion && irq_en) begin
                irq_flag <= 1'b1;
            end else if (wr_irq_rst && i_wdata[ttisgt_pkg::BIT_IRQ_TIMER]) begin
                irq_flag <= 1'b0;
            end
        end
    end
    assign o_timer_irq = irq_flag;

    // Read data, one cycle after the strobe
    logic [15:0] next_rdata;
    always_comb begin
        unique case (i_addr)
            ttisgt_pkg::OFS_IRQ_STATUS: next_rdata = {7'h00, i_module_irq[7:4], irq_flag,
                                                      i_module_irq[3:0]};
            ttisgt_pkg::OFS_TICK_SELECT: next_rdata = {15'h0000, tick_sel};
            ttisgt_pkg::OFS_SYNC_CTRL: next_rdata = {5'h00, sync_done, cap_req, tag_rst_req,
                                                     7'h00, cap_sbs[16]};
            ttisgt_pkg::OFS_SBS_LOW: next_rdata = cap_sbs[15:0];
            ttisgt_pkg::OFS_DAYS_HOURS: next_rdata = {cap_day, cap_hour};
            ttisgt_pkg::OFS_MIN_SEC: next_rdata = {1'b0, cap_min, 1'b0, cap_sec};
            ttisgt_pkg::OFS_CTRL_HIGH: next_rdata = {5'h00, cap_cf[26:16]};
            ttisgt_pkg::OFS_CTRL_LOW: next_rdata = cap_cf[15:0];
            ttisgt_pkg::OFS_REVISION: next_rdata = ttisgt_pkg::LOGIC_REVISION;
            ttisgt_pkg::OFS_PRESCALE: next_rdata = presc;
            ttisgt_pkg::OFS_PRELOAD: next_rdata = preload;
            ttisgt_pkg::OFS_TIMER_CTRL: next_rdata = {12'h000, grst_en, irq_en, reload_mode, run};
            ttisgt_pkg::OFS_TIMER_COUNT: next_rdata = count;
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            o_rdata <= i_rd_en ? next_rdata : 16'h0000;
        end
    end

    // Checks
    tick_source_a: assert property (int_tick && !tick_sel |=> o_time_tag_tick)
        else $error("internal tick not forwarded");
    revision_read_a: assert property (i_rd_en && i_addr == ttisgt_pkg::OFS_REVISION
        |=> o_rvalid && o_rdata == ttisgt_pkg::LOGIC_REVISION)
        else $error("revision read wrong");
    capture_done_a: assert property (cap_now |=> sync_done && !cap_req)
        else $error("capture did not complete");
    tag_reset_a: assert property (ref_hit |=> o_time_tag_reset && !tag_rst_req)
        else $error("tag reset not issued");
    capture_wait_a: assert property (tag_rst_req && cap_req && !ref_edge |=> cap_req)
        else $error("capture before reference edge");
    prescale_a: assert property (run && o_time_tag_tick && presc <= 16'h0001 |-> period_end)
        else $error("period length wrong");
    zero_start_a: assert property (wr_tctl && i_wdata[0] && !run && start_fresh
        && preload == 16'h0000 |=> !run)
        else $error("started with zero preload");
    one_shot_a: assert property (completion && !reload_mode |=> !run && count == 16'h0000)
        else $error("one-shot did not stop");
    reload_a: assert property (completion && reload_mode && preload != 16'h0000
        |=> run && count == $past(preload))
        else $error("reload failed");
    irq_set_a: assert property (completion && irq_en |=> irq_flag ##0 o_timer_irq)
        else $error("timer interrupt missing");
    global_reset_a: assert property (completion |=> o_module_reset_all == $past(grst_en))
        else $error("module reset mismatch");
    hold_count_a: assert property (!run && !wr_tctl |=> $stable(count))
        else $error("stopped count moved");
endmodule // ttisgt_top

// ### common/ttisgt_pkg.sv
package ttisgt_pkg;
    // Register byte offsets in the global bank
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_RESET = 8'h06;
    localparam logic [7:0] OFS_TICK_SELECT = 8'h10;
    localparam logic [7:0] OFS_SYNC_CTRL = 8'h14;
    localparam logic [7:0] OFS_SBS_LOW = 8'h16;
    localparam logic [7:0] OFS_DAYS_HOURS = 8'h18;
    localparam logic [7:0] OFS_MIN_SEC = 8'h1A;
    localparam logic [7:0] OFS_CTRL_HIGH = 8'h1C;
    localparam logic [7:0] OFS_CTRL_LOW = 8'h1E;
    localparam logic [7:0] OFS_REVISION = 8'h20;
    localparam logic [7:0] OFS_PRESCALE = 8'h22;
    localparam logic [7:0] OFS_PRELOAD = 8'h24;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h26;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h28;

    // Field positions
    localparam int BIT_TICK_EXT = 0;
    localparam int BIT_SYNC_TAG_RST = 8;
    localparam int BIT_SYNC_CAPTURE = 9;
    localparam int BIT_SYNC_DONE = 10;
    localparam int BIT_IRQ_TIMER = 4;
    localparam int BIT_TC_RUN = 0;
    localparam int BIT_TC_RELOAD = 1;
    localparam int BIT_TC_IRQ = 2;
    localparam int BIT_TC_GRST = 3;

    // Reset values
    localparam logic [15:0] RST_PRELOAD = 16'h0000;
    localparam logic [15:0] RST_PRESCALE = 16'h0000;
    localparam logic [3:0] RST_TIMER_CTRL = 4'h0;

    // Revision word; value is arbitrary
    localparam logic [15:0] LOGIC_REVISION = 16'h0001;

    // Frame positions of the time code fields
    localparam int POS_SEC = 1;
    localparam int POS_MIN = 10;
    localparam int POS_HOUR = 20;
    localparam int POS_DAY = 30;
    localparam int POS_CF = 50;
    localparam int POS_SBS = 80;
    localparam logic [6:0] POS_LAST = 7'd99;

    // Timing
    localparam int CLK_FREQ_MHZ = 200;
    localparam int TICK_PERIOD_US = 1;
    localparam int TICK_CYCLES = CLK_FREQ_MHZ * TICK_PERIOD_US;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    // Pulse width thresholds, in 1 us ticks
    localparam int ZERO_MAX_US = 3500;
    localparam int ONE_MAX_US = 6500;
    localparam logic [13:0] ZERO_MAX_TICKS = 14'(ZERO_MAX_US);
    localparam logic [13:0] ONE_MAX_TICKS = 14'(ONE_MAX_US);
endpackage

// ### verif/ttisgt_irig_src.sv
// Time code source: a demodulated pulse line, low between pulses
module ttisgt_irig_src (
    input wire logic i_ref_clk,
    output logic o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line rests low so a stale high never reads as a pulse
    initial o_level = 1'b0;
    // One pulse of the given width in microseconds, edges off the sampling edge
    task automatic pulse(input int us);
        @(negedge i_ref_clk) o_level = 1'b1;
        repeat (us * 200) @(negedge i_ref_clk);
        o_level = 1'b0;
    endtask
endmodule // ttisgt_irig_src

// ### verif/tb.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // One expected read answer with its compare mask
    typedef struct {string nm; logic [15:0] e; logic [15:0] m;} ttisgt_exp_t;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0;
    logic [7:0] addr = 8'h00, mirq, irq_clr, clr_seen = 8'h00;
    logic [15:0] wd = 16'h0000, rdata, last_rd;
    logic rvalid, tick, tag_rst, grst, tirq, irig;
    int bad_count = 0, n_checks = 0, n_tick = 0, n_grst = 0, el, seed = 84259;
    ttisgt_exp_t exp_q[$];
    ttisgt_exp_t ent;
    always #2.5 clk = ~clk;
    ttisgt_top ttisgt_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_en(wr), .i_rd_en(rd),
        .i_wdata(wd), .o_rdata(rdata), .o_rvalid(rvalid), .i_ext_tick(ext), .i_irig_level(irig),
        .i_module_irq(mirq), .o_module_irq_clr(irq_clr), .o_time_tag_tick(tick),
        .o_time_tag_reset(tag_rst), .o_module_reset_all(grst), .o_timer_irq(tirq));
    ttisgt_irig_src ttisgt_irig_src_i (.i_ref_clk(clk), .o_level(irig));
    // Pulse counters for the tick, tag reset and module reset outputs
    always @(posedge clk) begin
        if (tick === 1'b1) n_tick++;
        if (grst === 1'b1 || tag_rst === 1'b1) n_grst++;
    end
    // Last nonzero module interrupt reset pulse, taken where it is settled
    always @(negedge clk) if (rst_n && irq_clr !== 8'h00) clr_seen = irq_clr;
    // Read answers are taken off the queue in order, settled at the falling edge
    always @(negedge clk) if (rvalid === 1'b1) begin
        if (exp_q.size() == 0) `CHK("stray rvalid", 1'b0, 1'b1)
        else begin
            ent = exp_q.pop_front();
            last_rd = rdata;
            `CHK(ent.nm, ent.e & ent.m, rdata & ent.m)
        end
    end
    // Single write: strobe for exactly one cycle
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk) begin wr = 1'b1; addr = a; wd = d; end
        @(negedge clk) wr = 1'b0;
    endtask
    // Single read; the answer lands one cycle after the strobe is taken
    task automatic rd16(input string nm, input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back('{nm, e, m});
        @(negedge clk) begin rd = 1'b1; addr = a; end
        @(negedge clk) rd = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Bounded wait for timer irq (0) or a module reset pulse (1); el holds cycles spent
    task automatic wt(input int sel, input int lim);
        el = 0;
        while (!((sel == 0) ? tirq === 1'b1 : n_grst > 0)) begin
            @(negedge clk);
            el++;
            if (el > lim) begin bad_count++; end_sim(); end
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        mirq = 8'($random(seed));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd16("preload rst", 8'h24, 16'h0000, 16'hFFFF);
        rd16("ctrl rst", 8'h26, 16'h0000, 16'hFFFF);
        rd16("revision", 8'h20, ttisgt_pkg::LOGIC_REVISION, 16'hFFFF);
        rd16("unmapped", 8'h30, 16'h0000, 16'hFFFF);
        // Start with a zero preload must not run
        wr16(8'h26, 16'h0001);
        repeat (400) @(negedge clk);
        rd16("zero start", 8'h26, 16'h0000, 16'h0001);
        // One-shot, 2 us resolution, 3 counts, interrupt at completion
        wr16(8'h22, 16'h0002);
        wr16(8'h24, 16'h0003);
        wr16(8'h26, 16'h0005);
        wt(0, 1300);
        `CHK("oneshot time", 1'b1, el >= 800)
        rd16("oneshot count", 8'h28, 16'h0000, 16'hFFFF);
        rd16("oneshot ctrl", 8'h26, 16'h0004, 16'h000F);
        rd16("irq status", 8'h04, {7'h00, mirq[7:4], 1'b1, mirq[3:0]}, 16'hFFFF);
        wr16(8'h06, 16'h0000);
        `CHK("irq zero write", 1'b1, tirq)
        wr16(8'h06, {7'h00, mirq[7:4], 1'b1, mirq[3:0]});
        rd16("irq cleared", 8'h04, 16'h0000, 16'h0010);
        `CHK("irq clr", mirq, clr_seen)
        // Prescale 0 gives 1 us; global module reset at completion
        wr16(8'h22, 16'h0000);
        wr16(8'h26, 16'h0009);
        wt(1, 700);
        `CHK("grst time", 1'b1, el >= 400)
        repeat (20) @(negedge clk);
        `CHK("grst once", 1, n_grst)
        // Reload mode keeps running; refused preload write while running
        wr16(8'h22, 16'h0001);
        wr16(8'h24, 16'h0002);
        wr16(8'h26, 16'h0003);
        repeat (1500) @(negedge clk);
        rd16("reload run", 8'h26, 16'h0003, 16'h000F);
        `CHK("no irq", 1'b0, tirq)
        wr16(8'h24, 16'h0005);
        rd16("preload held", 8'h24, 16'h0002, 16'hFFFF);
        wr16(8'h26, 16'h0002);
        rd16("stop count", 8'h28, 16'h0000, 16'hFFFC);
        `CHK("count range", 1'b1, last_rd inside {16'h0001, 16'h0002})
        repeat (600) @(negedge clk);
        rd16("count held", 8'h28, last_rd, 16'hFFFF);
        // Tag reset request waits for a locked reference edge
        wr16(8'h14, 16'h0100);
        ttisgt_irig_src_i.pulse(2);
        rd16("sync pending", 8'h14, 16'h0300, 16'h0700);
        `CHK("no tag reset", 1, n_grst)
        // External tick source: ticks only on its rising edges
        wr16(8'h10, 16'h0001);
        repeat (5) @(negedge clk);
        n_tick = 0;
        repeat (600) @(negedge clk);
        repeat (3) begin
            ext = 1'b1;
            repeat (10) @(negedge clk);
            ext = 1'b0;
            repeat (10) @(negedge clk);
        end
        `CHK("ext ticks", 3, n_tick)
        rd16("select", 8'h10, 16'h0001, 16'h0001);
        end_sim();
    end
endmodule // tb
